// *** logic/adcsp_pkg.sv ***
/*
  Shared constants and types for the converter serial port and calibration control.
  Assumes a 20 MHz master clock and a 16-bit conversion word from the filter.
*/
`default_nettype none
package adcsp_pkg;

  // Word and frame geometry.
  localparam int           WORD_W       = 16;
  localparam int           FRAME_W      = 22;
  localparam logic [4:0]   SYNC_LEN     = 5'h10;
  localparam logic [4:0]   ASYNC_LEN    = 5'h16;
  localparam logic [15:0]  OFFSET_FLIP  = 16'h8000;

  // Last count of the conversion word period; the period is 1024 master clock cycles.
  localparam logic [9:0]   WORD_LAST    = 10'h3ff;

  // Calibrate must be high for this many cycles to count.
  localparam logic [2:0]   CAL_HOLD_MIN = 3'h4;

  // Self-clock phase on which a word may start, and the phase where the clock is high.
  localparam logic [1:0]   SSC_START_PH = 2'h1;
  localparam logic [1:0]   SSC_HIGH_PH  = 2'h0;

  // Filter settling after wake: 1.3 / 10 Hz corner, in microseconds.
  localparam int           CLK_MHZ        = 20;
  localparam int           SETTLE_TIME_US = 130000;
  localparam int           SETTLE_CYCLES  = SETTLE_TIME_US * CLK_MHZ;
  localparam int           SETTLE_W       = 22;

  // Positions in the synchronised pin vector.
  localparam int           PIN_W       = 7;
  localparam int           PIN_SCLK    = 0;
  localparam int           PIN_CS_N    = 1;
  localparam int           PIN_CAL     = 2;
  localparam int           PIN_SLEEP_N = 3;
  localparam int           PIN_SEL_A   = 4;
  localparam int           PIN_SEL_B   = 5;
  localparam int           PIN_POL     = 6;
  localparam logic [6:0]   PIN_RESET   = 7'h0a;

  typedef enum logic [1:0] {
    ADCSP_ASYNC_UART_MODE,
    ADCSP_SYNC_EXTERNAL_CLOCK_MODE,
    ADCSP_SYNC_SELF_CLOCK_MODE
  } adcsp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_READY,
    ST_SHIFT
  } adcsp_tx_t;

  typedef struct packed {
    adcsp_tx_t             tx;
    logic [9:0]            word_cnt;
    logic [FRAME_W-1:0]    tx_vec;
    logic [4:0]            bits_left;
    logic [1:0]            ssc_phase;
    logic                  sclk_out;
    logic                  sclk_oe;
    logic                  data_out;
    logic                  data_oe;
    logic                  result_ready_n_n;
    logic [PIN_W-1:0]      pins_prev;
    logic [2:0]            cal_hold;
    logic                  cal_long;
    logic                  cal_busy;
    logic                  cal_start;
    logic [1:0]            cal_mode;
    logic                  cal_bipolar;
    logic [SETTLE_W-1:0]   settle_cnt;
  } adcsp_state_t;

  localparam adcsp_state_t ST_RESET = '{
    tx: ST_IDLE, word_cnt: 10'h000, tx_vec: 22'h000000, bits_left: 5'h00,
    ssc_phase: 2'h0, sclk_out: 1'b0, sclk_oe: 1'b0, data_out: 1'b1,
    data_oe: 1'b0, result_ready_n_n: 1'b1, pins_prev: PIN_RESET, cal_hold: 3'h0,
    cal_long: 1'b0, cal_busy: 1'b0, cal_start: 1'b0, cal_mode: 2'h0,
    cal_bipolar: 1'b0, settle_cnt: 22'h000000};

  typedef struct packed {
    logic [PIN_W-1:0]      s1;
    logic [PIN_W-1:0]      s2;
    logic [PIN_W-1:0]      s3;
    logic [PIN_W-1:0]      clean;
  } adcsp_sync_t;

  localparam adcsp_sync_t SYNC_RESET = '{
    s1: PIN_RESET, s2: PIN_RESET, s3: PIN_RESET, clean: PIN_RESET};

endpackage
`default_nettype wire

// *** logic/adcsp_pins_if.sv ***
/*
  Carries the raw pin levels to the synchroniser and the cleaned levels back.
  Assumes both ends run on the master clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcsp_pins_if;
  import adcsp_pkg::*;
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface
`default_nettype wire

// *** logic/adcsp_sync.sv ***
/*
  Three-stage synchroniser for the asynchronous pins of the serial port block.
  Assumes the pins are quasi-static or slow against the master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsp_sync
  import adcsp_pkg::*;
(
  // Clock and control.
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Pin levels.
  adcsp_pins_if.sync       pins
);
  adcsp_sync_t st_ff;
  adcsp_sync_t nxt_st;
  logic [PIN_W-1:0] agree;

  // A level only counts once the second and third stages agree on it.
  always_comb begin
    agree        = ~(st_ff.s2 ^ st_ff.s3);
    nxt_st       = st_ff;
    nxt_st.s1    = pins.raw;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.clean = (st_ff.s3 & agree) | (st_ff.clean & ~agree);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff <= SYNC_RESET;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign pins.clean = st_ff.clean;
endmodule
`default_nettype wire

// *** logic/adcsp_core.sv ***
/*
  Serial output port, data-ready flag, calibration strobe and sleep control.
  Assumes the filter offers a word on result_i and a sequencer answers cal_done_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsp_core
  import adcsp_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
)(
  // Clock and control.
  input  wire logic               clock_i,
  input  wire logic               reset_i,
  input  wire logic               ce_i,
  // Configuration pins.
  input  wire logic [1:0]         mode_i,
  input  wire logic               chip_select_n_i,
  input  wire logic               cal_select_a_i,
  input  wire logic               cal_select_b_i,
  input  wire logic               polarity_select_i,
  input  wire logic               calibrate_i,
  input  wire logic               sleep_n_i,
  // Filter and sequencer side.
  input  wire logic [WORD_W-1:0]  result_i,
  input  wire logic               cal_done_i,
  output logic                    cal_start_o,
  output logic                    cal_busy_o,
  output logic [1:0]              cal_mode_o,
  output logic                    cal_bipolar_o,
  output logic                    core_reset_o,
  output logic                    low_power_o,
  output logic                    settling_o,
  // Serial link.
  input  wire logic               serial_clock_i,
  output logic                    serial_clock_o,
  output logic                    serial_clock_oe_o,
  output logic                    serial_out_line_o,
  output logic                    serial_out_line_oe_o,
  output logic                    result_ready_n_o
);
  adcsp_state_t     st_ff;
  adcsp_state_t     nxt_st;
  adcsp_mode_t      mode;
  logic [PIN_W-1:0] pin;
  logic             sclk_fall;
  logic             tick;
  logic             halted;
  logic             cal_fall;

  adcsp_pins_if pins_if ();
  assign pins_if.raw = {polarity_select_i, cal_select_b_i, cal_select_a_i, sleep_n_i,
                        calibrate_i, chip_select_n_i, serial_clock_i};
  assign pin = pins_if.clean;

  adcsp_sync u_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .pins    (pins_if.sync)
  );

  // Builds the shift vector; the async frame sends the high byte first, LSB first.
  function automatic logic [FRAME_W-1:0] build_frame(input adcsp_mode_t m,
                                                     input logic [WORD_W-1:0] w);
    logic [FRAME_W-1:0] f;
    logic [7:0]         hi;
    logic [7:0]         lo;
    f = {w, 6'h00};
    for (int i = 0; i < 8; i++) begin
      hi[7-i] = w[8+i];
      lo[7-i] = w[i];
    end
    if (m == ADCSP_ASYNC_UART_MODE) begin
      f = {1'b0, hi, 2'h3, 1'b0, lo, 2'h3};
    end
    return f;
  endfunction

  assign mode      = adcsp_mode_t'(mode_i);
  assign sclk_fall = st_ff.pins_prev[PIN_SCLK] & ~pin[PIN_SCLK];
  assign cal_fall  = st_ff.pins_prev[PIN_CAL] & ~pin[PIN_CAL];
  assign halted    = pin[PIN_CAL] | st_ff.cal_busy | ~pin[PIN_SLEEP_N];
  // Bits advance on the falling serial clock edge; the partner samples on the rise.
  assign tick      = (mode == ADCSP_SYNC_SELF_CLOCK_MODE) ? (st_ff.ssc_phase == SSC_HIGH_PH)
                                                          : sclk_fall;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.pins_prev = pin;
    nxt_st.cal_start = 1'b0;
    nxt_st.ssc_phase = st_ff.ssc_phase + 2'h1;
    nxt_st.sclk_out  = (nxt_st.ssc_phase == SSC_HIGH_PH);

    // Calibrate strobe: only a long enough high counts, glitches fall away.
    if (pin[PIN_CAL]) begin
      if (st_ff.cal_hold != CAL_HOLD_MIN) begin
        nxt_st.cal_hold = st_ff.cal_hold + 3'h1;
      end
      nxt_st.cal_long = (nxt_st.cal_hold == CAL_HOLD_MIN);
    end else begin
      nxt_st.cal_hold = 3'h0;
      nxt_st.cal_long = 1'b0;
    end
    if (cal_fall && st_ff.cal_long) begin
      nxt_st.cal_start   = 1'b1;
      nxt_st.cal_busy    = 1'b1;
      nxt_st.cal_mode    = {pin[PIN_SEL_B], pin[PIN_SEL_A]};
      nxt_st.cal_bipolar = pin[PIN_POL];
    end else if (cal_done_i) begin
      nxt_st.cal_busy = 1'b0;
    end

    // Settling after wake; coefficients and settings stay as they were.
    if (st_ff.settle_cnt != '0) begin
      nxt_st.settle_cnt = st_ff.settle_cnt - 22'h000001;
    end
    if (pin[PIN_SLEEP_N] && !st_ff.pins_prev[PIN_SLEEP_N]) begin
      nxt_st.settle_cnt = SETTLE_CYCLES_P[SETTLE_W-1:0];
    end

    // Word timer restarts from zero on wake so devices line up.
    if (halted) begin
      nxt_st.word_cnt = 10'h000;
    end else begin
      nxt_st.word_cnt = st_ff.word_cnt + 10'h001;
    end

    unique case (st_ff.tx)
      ST_IDLE, ST_READY: begin
        if (st_ff.tx == ST_READY && !pin[PIN_CS_N] &&
            (mode != ADCSP_SYNC_SELF_CLOCK_MODE || st_ff.ssc_phase == SSC_START_PH)) begin
          nxt_st.tx        = ST_SHIFT;
          nxt_st.data_oe   = 1'b1;
          nxt_st.data_out  = st_ff.tx_vec[FRAME_W-1];
          nxt_st.sclk_oe   = (mode == ADCSP_SYNC_SELF_CLOCK_MODE);
        end
      end
      ST_LOAD: begin
        nxt_st.tx     = ST_READY;
        nxt_st.result_ready_n_n = 1'b0;
      end
      ST_SHIFT: begin
        if (pin[PIN_CS_N]) begin
          nxt_st.tx      = ST_IDLE;
          nxt_st.result_ready_n_n  = 1'b1;
          nxt_st.data_oe = 1'b0;
          nxt_st.sclk_oe = 1'b0;
        end else if (tick) begin
          if (st_ff.bits_left == 5'h01) begin
            nxt_st.tx      = ST_IDLE;
            nxt_st.result_ready_n_n  = 1'b1;
            nxt_st.data_oe = 1'b0;
            nxt_st.sclk_oe = 1'b0;
          end else begin
            nxt_st.tx_vec    = {st_ff.tx_vec[FRAME_W-2:0], 1'b1};
            nxt_st.data_out  = st_ff.tx_vec[FRAME_W-2];
            nxt_st.bits_left = st_ff.bits_left - 5'h01;
          end
        end
      end
    endcase

    // A fresh word replaces an untaken one; one that arrives while a word is on the wire is dropped.
    if (!halted && st_ff.word_cnt == WORD_LAST && st_ff.tx != ST_SHIFT) begin
      nxt_st.tx        = ST_LOAD;
      nxt_st.result_ready_n_n    = 1'b1;
      nxt_st.tx_vec    = build_frame(mode, st_ff.cal_bipolar ? (result_i ^ OFFSET_FLIP)
                                                             : result_i);
      nxt_st.bits_left = (mode == ADCSP_ASYNC_UART_MODE) ? ASYNC_LEN : SYNC_LEN;
    end
    if (halted) begin
      nxt_st.tx      = ST_IDLE;
      nxt_st.result_ready_n_n  = 1'b1;
      nxt_st.data_oe = 1'b0;
      nxt_st.sclk_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff <= ST_RESET;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign serial_clock_o       = st_ff.sclk_out;
  assign serial_clock_oe_o    = st_ff.sclk_oe;
  assign serial_out_line_o    = st_ff.data_out;
  assign serial_out_line_oe_o = st_ff.data_oe;
  assign result_ready_n_o     = st_ff.result_ready_n_n;
  assign cal_start_o          = st_ff.cal_start;
  assign cal_busy_o           = st_ff.cal_busy;
  assign cal_mode_o           = st_ff.cal_mode;
  assign cal_bipolar_o        = st_ff.cal_bipolar;
  assign core_reset_o         = pin[PIN_CAL];
  assign low_power_o          = ~pin[PIN_SLEEP_N];
  assign settling_o           = (st_ff.settle_cnt != '0);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || !ce_i);

  sequence s_word_loaded;
    st_ff.tx == ST_LOAD && result_ready_n_o;
  endsequence
  sequence s_ready_low;
    !result_ready_n_o && st_ff.tx == ST_READY;
  endsequence

  a_data_tristate_idle: assert property (st_ff.tx != ST_SHIFT |-> !serial_out_line_oe_o)
    else $error("Data line driven with no word in flight.");
  a_sclk_quarter_duty: assert property ($rose(serial_clock_o) |=>
      !serial_clock_o [*3] ##1 serial_clock_o)
    else $error("Self clock is not master over four at one quarter high.");
  a_word_period_load: assert property ((!halted && st_ff.word_cnt == WORD_LAST &&
      st_ff.tx != ST_SHIFT && !$past(halted)) |=> s_word_loaded ##1 s_ready_low)
    else $error("Word load and ready fall missed the period boundary.");
  a_cal_keeps_high: assert property (cal_busy_o |-> result_ready_n_o)
    else $error("Data ready low during calibration.");
  a_sleep_result_ready_n_high: assert property (low_power_o |=> result_ready_n_o &&
      !serial_out_line_oe_o)
    else $error("Port active while asleep.");
  a_deselect_abort: assert property ((st_ff.tx == ST_SHIFT && pin[PIN_CS_N]) |=>
      !serial_out_line_oe_o && !serial_clock_oe_o && result_ready_n_o)
    else $error("Deselect did not stop the word.");
  a_last_bit_result_ready_n: assert property ((st_ff.tx == ST_SHIFT && !pin[PIN_CS_N] && !halted &&
      tick && st_ff.bits_left == 5'h01) |=> result_ready_n_o && !serial_out_line_oe_o)
    else $error("Data ready did not rise on the last bit.");
  a_cal_sample_fall: assert property ((cal_fall && st_ff.cal_long) |=>
      cal_start_o && cal_mode_o == $past(pin[PIN_SEL_B:PIN_SEL_A]) &&
      cal_bipolar_o == $past(pin[PIN_POL]))
    else $error("Calibration settings not captured at the strobe fall.");
  a_short_cal_ignored: assert property ((cal_fall && !st_ff.cal_long) |=> !cal_start_o)
    else $error("Short calibrate pulse started a calibration.");
  a_offset_binary: assert property ((st_ff.tx == ST_LOAD &&
      mode == ADCSP_SYNC_EXTERNAL_CLOCK_MODE && $stable(mode_i)) |->
      st_ff.tx_vec[FRAME_W-1] == ($past(result_i[WORD_W-1]) ^ cal_bipolar_o))
    else $error("Bipolar word not sent as offset binary.");
  a_sleep_keeps_cal: assert property ((low_power_o && !pin[PIN_CAL] && !cal_fall) |=>
      $stable(cal_mode_o) && $stable(cal_bipolar_o))
    else $error("Sleep disturbed the calibration settings.");
endmodule
`default_nettype wire

// *** bench/adcsp_host_model.sv ***
/*
  Host model for the serial link: selects the port, clocks the bits in external-clock mode and collects them.
  Assumes the bench feeds it the resolved levels of the data and clock wires.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsp_host_model (
  // Master clock.
  input  wire logic  clock_i,
  // Serial link.
  input  wire logic  serial_out_line_i,
  input  wire logic  sclk_i,
  output logic       sclk_o,
  output logic       cs_n_o
);
  logic [21:0] got;
  int          per;

  // The link clock stands still between frames.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end

  // Reads n bits, or stops after cut bits to abandon a word halfway.
  task automatic read_word(input logic self, input int n, input int cut);
    int k;
    int last;
    k = 0;
    last = 0;
    got = '0;
    per = 0;
    cs_n_o = 1'b0;
    if (!self) begin
      #413;
      while (k < n && k < cut) begin
        sclk_o = 1'b1;
        #199;
        got = {got[20:0], serial_out_line_i};
        #1;
        sclk_o = 1'b0;
        #200;
        k++;
      end
    end else begin
      for (int c = 0; c < 3000 && k < n && k < cut; c++) begin
        @(negedge clock_i);
        if (sclk_i === 1'b1) begin
          if (k > 0 && c - last != 4) per++;
          last = c;
          got = {got[20:0], serial_out_line_i};
          k++;
        end
      end
    end
    got = got << (22 - k);
    #400;
    cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Self-checking bench for the converter serial port and calibration control.
  Assumes the host model on the link and a 20 MHz master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  mode = 2'h1;
  logic        sel_a = 1'b0;
  logic        sel_b = 1'b0;
  logic        pol = 1'b0;
  logic        cal = 1'b0;
  logic        sleep_n = 1'b1;
  logic        cal_done = 1'b0;
  logic [15:0] result = 16'h0000;
  logic        c_start, c_busy, c_bip, c_rst, lp, settling;
  logic [1:0]  c_mode;
  logic        sclk_d, sclk_oe, sd, sd_oe, rdy_n;
  logic        sd_last = 1'b1;
  logic        bip = 1'b0;
  wire logic   sclk_w, sd_w, cs_n, sclk_h;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          c;

  // A released data line shows the inverse of its last level, so stale bits never match.
  assign sclk_w = sclk_oe ? sclk_d : sclk_h;
  assign sd_w   = sd_oe ? sd : ~sd_last;
  always @(posedge clk) if (sd_oe) sd_last <= sd;
  always #25 clk = ~clk;

  adcsp_core #(.SETTLE_CYCLES_P(50)) uut (
    .clock_i(clk), .reset_i(rst), .ce_i(1'b1), .mode_i(mode), .chip_select_n_i(cs_n),
    .cal_select_a_i(sel_a), .cal_select_b_i(sel_b), .polarity_select_i(pol),
    .calibrate_i(cal), .sleep_n_i(sleep_n), .result_i(result), .cal_done_i(cal_done),
    .cal_start_o(c_start), .cal_busy_o(c_busy), .cal_mode_o(c_mode),
    .cal_bipolar_o(c_bip), .core_reset_o(c_rst), .low_power_o(lp),
    .settling_o(settling), .serial_clock_i(sclk_w), .serial_clock_o(sclk_d),
    .serial_clock_oe_o(sclk_oe), .serial_out_line_o(sd),
    .serial_out_line_oe_o(sd_oe), .result_ready_n_o(rdy_n));

  adcsp_host_model host (.clock_i(clk), .serial_out_line_i(sd_w), .sclk_i(sclk_w),
    .sclk_o(sclk_h), .cs_n_o(cs_n));

  task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wait_fall(output int cnt);
    cnt = 0;
    while (rdy_n !== 1'b1 && cnt < 2100) begin tick(1); cnt++; end
    while (rdy_n !== 1'b0 && cnt < 2100) begin tick(1); cnt++; end
    // A missing ready fall is a failure, not a silent skip.
    if (cnt >= 2100) begin
      n_fail++;
      $display("BAD ready fall expected within 2100 seen none");
    end
  endtask

  // Bits in the order they leave the port, first bit at the top.
  function automatic logic [21:0] frame(input logic [1:0] m, input logic [15:0] w,
                                        input logic b);
    logic [15:0] v;
    logic [21:0] f;
    v = b ? (w ^ OFFSET_FLIP) : w;
    f = 22'h001803;
    for (int i = 0; i < 8; i++) begin
      f[20-i] = v[8+i];
      f[9-i] = v[i];
    end
    return (m == 2'h0) ? f : {v, 6'h00};
  endfunction

  task automatic read(input logic [1:0] m, input int cut);
    logic [21:0] e;
    mode = m;
    result = 16'($urandom);
    wait_fall(c);
    e = frame(m, result, bip);
    host.read_word(m == 2'h2, (m == 2'h0) ? 22 : 16, cut);
    if (cut > 22) begin
      check("word", e, host.got);
      check("ready_n after word", 22'h1, 22'(rdy_n));
      check("clock spacing", 22'h0, 22'(host.per));
    end else begin
      tick(6);
      check("ready_n after deselect", 22'h1, 22'(rdy_n));
    end
    check("data enable idle", 22'h0, 22'(sd_oe));
    check("clock enable idle", 22'h0, 22'(sclk_oe));
  endtask

  task automatic calib(input logic [1:0] s, input logic p, input int len);
    int k;
    k = 0;
    {sel_b, sel_a} = s;
    pol = p;
    cal = 1'b1;
    tick(len);
    if (len > 4) check("core reset", 22'h1, 22'(c_rst));
    cal = 1'b0;
    while (c_start !== 1'b1 && k < 12) begin tick(1); k++; end
    check("cal start", 22'(len > 4), 22'(c_start));
    if (len > 4) begin
      {sel_b, sel_a} = ~s;
      pol = ~p;
      tick(6);
      check("cal mode", 22'(s), 22'(c_mode));
      check("cal polarity", 22'(p), 22'(c_bip));
      tick(40);
      check("ready_n in cal", 22'h1, 22'(rdy_n));
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
      tick(1);
      check("cal busy", 22'h0, 22'(c_busy));
      {sel_b, sel_a} = s;
      pol = p;
      bip = p;
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #3000000;
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(92));
    tick(12);
    rst = 1'b0;
    tick(2);
    wait_fall(c);
    wait_fall(c);
    check("ready period", 22'd1024, 22'(c));
    read(2'h1, 99);
    for (int i = 0; i < 4; i++) calib(2'(i), i[1], 6);
    calib(2'h1, 1'b0, 2);
    read(2'h1, 99);
    read(2'h0, 99);
    read(2'h2, 99);
    calib(2'h2, 1'b0, 6);
    read(2'h0, 99);
    read(2'h1, 5);
    read(2'h1, 99);
    sleep_n = 1'b0;
    tick(8);
    check("low power", 22'h1, 22'(lp));
    c = 0;
    repeat (1100) begin tick(1); if (rdy_n !== 1'b1) c++; end
    check("ready_n in sleep", 22'h0, 22'(c));
    sleep_n = 1'b1;
    tick(6);
    check("settling", 22'h1, 22'(settling));
    check("mode kept", 22'h2, 22'(c_mode));
    tick(60);
    check("settled", 22'h0, 22'(settling));
    read(2'h2, 99);
    repeat (3) read(2'($urandom_range(2)), 99);
    wrap_up();
  end
endmodule
`default_nettype wire
